// ===== hdl/ucsf_status.sv
// Overview of operation
// R01: break char sets break flag, one entry
// R02: stop bit not one gives framing error
// R03: parity mismatch flags error when parity enabled
// R04: multidrop puts address/data bit in parity slot
// R05: new start while full and waiting sets overrun
// R06: overrun discards waiting character and its status
// R07: overrun cleared only by error reset command
// R08: enabling from off sets empty and ready
// R09: empty set after last stop, nothing queued
// R10: empty cleared by load, disable or reset
// R11: ready follows free transmit slot
// R12: ready cleared on disable, set on enable while a transmit slot is free
// R13: writes while ready low are dropped
// R14: fifo full set on filling push, cleared on read
// R15: fifo full held when waiting char refills slot
// R16: receiver ready set on push, cleared when emptied
// R17: error bits stored per char, head shown
// R18: character mode drops error bits on read
// R19: block mode accumulates until error or rx reset
// R20: channel b mirrors channel a layout
// R21: status registers are read only
`timescale 1ns/1ps
module ucsf_status #(
    parameter int TX_DEPTH = ucsf_pkg::TX_DEPTH_DEF
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [ucsf_pkg::ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_start,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_char_done,
    input  wire logic [ucsf_pkg::NUM_CH-1:0][7:0]     rx_data,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_break,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_stop_bit,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_parity_bit,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          rx_line_mark,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          tx_take,
    input  wire logic [ucsf_pkg::NUM_CH-1:0]          tx_last_stop,
    output logic      [ucsf_pkg::NUM_CH-1:0]          tx_char_valid,
    output logic      [ucsf_pkg::NUM_CH-1:0][7:0]     tx_char
);
    import ucsf_pkg::*;

    localparam int TAW = $clog2(TX_DEPTH);
    localparam int RAW = $clog2(RX_DEPTH_LARGE);
    localparam logic [TAW:0] TX_LIMIT = TX_DEPTH[TAW:0];
    localparam logic [RAW:0] RX_LIM_S = RX_DEPTH_SMALL[RAW:0];
    localparam logic [RAW:0] RX_LIM_L = RX_DEPTH_LARGE[RAW:0];

    if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin
        $error("TX_DEPTH must be a power of two of at least two");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic [IDX_W-1:0]       idx;
    logic                   setup, acc, acc_wr, acc_rd, hit;
    logic [NUM_CH-1:0]      sel_mode, sel_stat, sel_cmd, sel_data;
    logic [NUM_CH-1:0][7:0] rd_mode, rd_stat, rd_data;
    logic [31:0]            rd_val, prdata_q;
    logic                   pready_q, pslverr_q;

    assign idx    = paddr[ADDR_W-1:2];
    assign setup  = psel & ~penable;
    assign acc    = psel & penable & pready_q;
    assign acc_wr = acc & pwrite;
    assign acc_rd = acc & ~pwrite;
    always_comb begin
        rd_val = 32'h0000_0000;
        hit    = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (sel_mode[c]) begin
                rd_val = {24'h00_0000, rd_mode[c]};
                hit    = 1'b1;
            end else if (sel_stat[c]) begin
                rd_val = {24'h00_0000, rd_stat[c]};
                hit    = 1'b1;
            end else if (sel_cmd[c]) begin
                hit    = 1'b1;
            end else if (sel_data[c]) begin
                rd_val = {24'h00_0000, rd_data[c]};
                hit    = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    ////////////////////////////////////////////////////////////////////////
    // per channel status logic

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [IDX_W-1:0] OFS = IDX_W'(i) * IDX_CH_STEP;

        logic [7:0]   mode_q, txc_q, cmd, tx_dout;
        logic [10:0]  wait_q, new_bits, rx_din, rx_dout;
        logic [2:0]   err_acc_q, head_err;
        logic [RAW:0] rx_cnt, rx_lim;
        logic [TAW:0] tx_cnt;
        logic         rx_en_q, ovr_q, brk_hold_q, wait_v_q, ffull_q, rxrdy_q, txrdy_q, txemt_q, txv_q;
        logic         do_cmd, rst_rx, rst_tx, rst_err, pe_bit, ch_ok, cpu_pop, accept, take;
        logic         push_wait, push_new, rx_push, rx_empty, rx_full, overrun, tx_empty;
        ucsf_tx_t     tx_st_q;
        ucsf_misc_t   misc;
        ucsf_par_t    par;

        assign sel_mode[i] = psel & (idx == IDX_MODE_A + OFS);
        assign sel_stat[i] = psel & (idx == IDX_STATUS_A + OFS); // R20
        assign sel_cmd[i]  = psel & (idx == IDX_CMD_A + OFS);
        assign sel_data[i] = psel & (idx == IDX_DATA_A + OFS);
        assign cmd     = pwdata[7:0];
        assign misc    = ucsf_misc_t'(cmd[CMD_MISC_LSB +: 4]);
        assign do_cmd  = acc_wr & sel_cmd[i];
        assign rst_rx  = do_cmd & (misc == MISC_RST_RX);
        assign rst_tx  = do_cmd & (misc == MISC_RST_TX);
        assign rst_err = do_cmd & (misc == MISC_RST_ERR);

        // mode register; status has no write path
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_q <= MODE_RST;
            end else if (acc_wr & sel_mode[i]) begin // R21
                mode_q <= pwdata[7:0];
            end
        end

        ////////////////////////////////////////////////////////////////////
        // receive side

        assign par = ucsf_par_t'(mode_q[MD_PAR_LSB +: 2]);
        always_comb begin
            case (par)
                PAR_WITH:  pe_bit = (^rx_data[i] ^ rx_parity_bit[i]) != mode_q[MD_PAR_ODD]; // R03
                PAR_FORCE: pe_bit = rx_parity_bit[i] != mode_q[MD_PAR_ODD]; // R03
                PAR_MULTI: pe_bit = rx_parity_bit[i]; // R04
                default:   pe_bit = 1'b0;
            endcase
        end

        // error bits ride with the character
        assign new_bits = {rx_break[i], ~rx_stop_bit[i], pe_bit, rx_data[i]}; // R01 R02 R17
        assign ch_ok    = rx_char_done[i] & rx_en_q & ~brk_hold_q; // R01
        assign rx_lim   = mode_q[MD_FIFO16] ? RX_LIM_L : RX_LIM_S; // R14
        assign cpu_pop  = acc_rd & sel_data[i] & ~rx_empty;
        assign push_wait = wait_v_q & (~rx_full | cpu_pop); // R15
        assign push_new  = ch_ok & ~wait_v_q & (~rx_full | cpu_pop);
        assign rx_push   = push_wait | push_new;
        assign rx_din    = push_wait ? wait_q : new_bits;
        assign overrun   = rx_start[i] & rx_full & wait_v_q & ~cpu_pop; // R05
        ucsf_fifo #(
            .WIDTH (11),
            .DEPTH (RX_DEPTH_LARGE)
        ) u_rx_fifo (
            .pclk    (pclk),
            .presetn (presetn),
            .flush   (rst_rx),
            .push    (rx_push),
            .pop     (cpu_pop),
            .din     (rx_din),
            .limit   (rx_lim),
            .dout    (rx_dout),
            .count   (rx_cnt),
            .empty   (rx_empty),
            .full    (rx_full)
        );

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rx_en_q <= 1'b0;
            end else if (rst_rx) begin
                rx_en_q <= 1'b0;
            end else if (do_cmd & cmd[CMD_RX_EN]) begin
                rx_en_q <= 1'b1;
            end else if (do_cmd & cmd[CMD_RX_DIS]) begin
                rx_en_q <= 1'b0;
            end
        end

        // character held in the shift register while the fifo is full
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wait_v_q <= 1'b0;
                wait_q   <= 11'h000;
            end else if (rst_rx | overrun) begin
                wait_v_q <= 1'b0; // R06
            end else if (ch_ok & ~push_new) begin
                wait_v_q <= 1'b1;
                wait_q   <= new_bits;
            end else if (push_wait) begin
                wait_v_q <= 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                brk_hold_q <= 1'b0;
            end else if (ch_ok & rx_break[i]) begin
                brk_hold_q <= 1'b1; // R01
            end else if (rst_rx | rx_line_mark[i]) begin
                brk_hold_q <= 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ovr_q <= 1'b0;
            end else if (overrun) begin
                ovr_q <= 1'b1; // R05
            end else if (rst_err) begin
                ovr_q <= 1'b0; // R07
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                err_acc_q <= 3'b000;
            end else if (rx_push) begin
                err_acc_q <= (rst_err ? 3'b000 : err_acc_q) | rx_din[10:8]; // R19
            end else if (rst_err | rst_rx) begin
                err_acc_q <= 3'b000; // R19
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ffull_q <= 1'b0;
                rxrdy_q <= 1'b0;
            end else if (rst_rx) begin
                ffull_q <= 1'b0;
                rxrdy_q <= 1'b0;
            end else begin
                if (rx_push & ~cpu_pop & (rx_cnt + 1'b1 == rx_lim)) begin
                    ffull_q <= 1'b1; // R14
                end else if (cpu_pop & ~rx_push) begin
                    ffull_q <= 1'b0; // R14 R15
                end
                if (rx_push) begin
                    rxrdy_q <= 1'b1; // R16
                end else if (cpu_pop & (rx_cnt == {{RAW{1'b0}}, 1'b1})) begin
                    rxrdy_q <= 1'b0; // R16
                end
            end
        end

        // head error bits disappear with their character in character mode
        assign head_err = rx_empty ? 3'b000 : rx_dout[10:8]; // R18
        assign rd_stat[i] = {mode_q[MD_BLOCK] ? err_acc_q : head_err, // R17
                             ovr_q, txemt_q, txrdy_q, ffull_q, rxrdy_q};
        assign rd_data[i] = rx_empty ? 8'h00 : rx_dout[7:0];
        assign rd_mode[i] = mode_q;
        ////////////////////////////////////////////////////////////////////
        // transmit side

        assign accept = acc_wr & sel_data[i] & txrdy_q; // R13
        assign take   = tx_take[i] & ~tx_empty & (tx_st_q != TX_OFF);
        ucsf_fifo #(
            .WIDTH (8),
            .DEPTH (TX_DEPTH)
        ) u_tx_fifo (
            .pclk    (pclk),
            .presetn (presetn),
            .flush   (rst_tx),
            .push    (accept),
            .pop     (take),
            .din     (pwdata[7:0]),
            .limit   (TX_LIMIT),
            .dout    (tx_dout),
            .count   (tx_cnt),
            .empty   (tx_empty),
            .full    ()
        );

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_st_q <= TX_OFF;
                txrdy_q <= 1'b0;
                txemt_q <= 1'b0;
            end else if (rst_tx) begin
                tx_st_q <= TX_OFF; // R10
                txrdy_q <= 1'b0;
                txemt_q <= 1'b0;
            end else begin
                case (tx_st_q)
                    TX_OFF: begin
                        if (do_cmd & cmd[CMD_TX_EN]) begin
                            tx_st_q <= TX_ON;
                            txrdy_q <= 1'b1; // R08 R12
                            txemt_q <= 1'b1; // R08
                        end
                    end
                    TX_ON: begin
                        if (do_cmd & cmd[CMD_TX_DIS]) begin
                            txrdy_q <= 1'b0; // R12
                            if (txemt_q) begin
                                tx_st_q <= TX_OFF;
                                txemt_q <= 1'b0; // R10
                            end else begin
                                tx_st_q <= TX_DRAIN;
                            end
                        end else begin
                            if (accept & ~take & (tx_cnt + 1'b1 == TX_LIMIT)) begin
                                txrdy_q <= 1'b0; // R11
                            end else if (take) begin
                                txrdy_q <= 1'b1; // R11
                            end
                            if (accept) begin
                                txemt_q <= 1'b0; // R10
                            end else if (tx_last_stop[i] & tx_empty) begin
                                txemt_q <= 1'b1; // R09
                            end
                        end
                    end
                    TX_DRAIN: begin
                        if (do_cmd & cmd[CMD_TX_EN]) begin
                            tx_st_q <= TX_ON;
                            txrdy_q <= (tx_cnt < TX_LIMIT) | take; // R12
                        end else if (tx_last_stop[i] & tx_empty) begin
                            tx_st_q <= TX_OFF;
                            txemt_q <= 1'b0; // R10
                        end
                    end
                    default: begin
                        tx_st_q <= TX_OFF;
                    end
                endcase
            end
        end

        // presented character; held off one cycle after each take
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                txv_q <= 1'b0;
                txc_q <= 8'h00;
            end else begin
                txv_q <= ~tx_empty & (tx_st_q != TX_OFF) & ~take & ~rst_tx;
                txc_q <= tx_dout;
            end
        end

        assign tx_char_valid[i] = txv_q;
        assign tx_char[i]       = txc_q;
    end
endmodule

// ===== hdl/ucsf_pkg.sv
package ucsf_pkg;
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 6;
    localparam int IDX_W  = 4;

    // register indexes, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODE_A   = 4'h0;
    localparam logic [IDX_W-1:0] IDX_STATUS_A = 4'h1;
    localparam logic [IDX_W-1:0] IDX_CMD_A    = 4'h2;
    localparam logic [IDX_W-1:0] IDX_DATA_A   = 4'h3;
    localparam logic [IDX_W-1:0] IDX_STATUS_B = 4'h9;
    localparam logic [IDX_W-1:0] IDX_CH_STEP  = IDX_STATUS_B - IDX_STATUS_A;

    // status bit positions
    localparam int ST_BRK    = 7;
    localparam int ST_FE     = 6;
    localparam int ST_PE     = 5;
    localparam int ST_OVR    = 4;
    localparam int ST_TXEMT  = 3;
    localparam int ST_TXRDY  = 2;
    localparam int ST_RXFULL = 1;
    localparam int ST_RXRDY  = 0;

    // mode register fields
    localparam int MD_PAR_LSB = 0;
    localparam int MD_PAR_ODD = 2;
    localparam int MD_BLOCK   = 3;
    localparam int MD_FIFO16  = 4;
    localparam logic [7:0] MODE_RST = 8'h00;

    // command register fields
    localparam int CMD_RX_EN  = 0;
    localparam int CMD_RX_DIS = 1;
    localparam int CMD_TX_EN  = 2;
    localparam int CMD_TX_DIS = 3;
    localparam int CMD_MISC_LSB = 4;

    localparam int RX_DEPTH_SMALL = 8;
    localparam int RX_DEPTH_LARGE = 16;
    localparam int TX_DEPTH_DEF   = 8;

    typedef enum logic [1:0] {
        PAR_WITH  = 2'b00,
        PAR_FORCE = 2'b01,
        PAR_NONE  = 2'b10,
        PAR_MULTI = 2'b11
    } ucsf_par_t;

    typedef enum logic [3:0] {
        MISC_NOP     = 4'h0,
        MISC_RST_RX  = 4'h2,
        MISC_RST_TX  = 4'h3,
        MISC_RST_ERR = 4'h4
    } ucsf_misc_t;

    typedef enum logic [1:0] {
        TX_OFF   = 2'b00,
        TX_ON    = 2'b01,
        TX_DRAIN = 2'b10
    } ucsf_tx_t;
endpackage

// ===== hdl/ucsf_fifo.sv
`timescale 1ns/1ps
module ucsf_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     flush,
    input  wire logic                     push,
    input  wire logic                     pop,
    input  wire logic [WIDTH-1:0]         din,
    input  wire logic [$clog2(DEPTH):0]   limit,
    output logic      [WIDTH-1:0]         dout,
    output logic      [$clog2(DEPTH):0]   count,
    output logic                          empty,
    output logic                          full
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
        $error("fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    logic             do_push;
    logic             do_pop;

    assign do_pop  = pop & (cnt_q != '0);
    assign do_push = push & ((cnt_q < limit) | do_pop);
    assign dout    = mem[rd_ptr_q];
    assign count   = cnt_q;
    assign empty   = (cnt_q == '0);
    assign full    = (cnt_q >= limit);

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= din;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (do_push & ~do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop & ~do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ===== testbench/ucsf_line_model.sv
`timescale 1ns/1ps
module ucsf_line_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       hold,
    input  wire logic       valid,
    input  wire logic [7:0] char_in,
    output logic            take,
    output logic            last_stop
);
    logic [7:0] sent[$];
    int         cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take <= 1'b0;
            last_stop <= 1'b0;
            cnt <= 0;
        end else begin
            take <= 1'b0;
            last_stop <= (cnt == 1);
            if (cnt > 0) begin
                cnt <= cnt - 1;
            end else if (valid && !take && !hold) begin
                take <= 1'b1;
                sent.push_back(char_in);
                cnt <= 5;
            end
        end
    end
endmodule

// ===== testbench/ucsf_status_checker.sv
`timescale 1ns/1ps
module ucsf_status_checker (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ucsf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [ucsf_pkg::NUM_CH-1:0] tx_take,
    input wire logic [ucsf_pkg::NUM_CH-1:0] tx_char_valid
);
    import ucsf_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_st;
    assign rd_st = pready && !pwrite && paddr[4:2] == 3'b001;
    setup_answer_a: assert property (psel && !penable |=> pready && pslverr == $past(paddr[4]))
        else $error("bad answer to setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    full_ready_a: assert property (rd_st && prdata[ST_RXFULL] |-> prdata[ST_RXRDY])
        else $error("full without ready");
    empty_ready_a: assert property (rd_st && prdata[ST_TXEMT] |-> prdata[ST_TXRDY])
        else $error("empty without ready");
    take_drop_a: assert property (tx_take[0] && tx_char_valid[0] |=> !tx_char_valid[0])
        else $error("valid kept after take");
    cover property (pslverr);
    cover property (tx_take[0] && tx_char_valid[0]);
    cover property (rd_st && prdata[ST_OVR]);
endmodule

bind ucsf_status ucsf_status_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_take(tx_take), .tx_char_valid(tx_char_valid)
);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import ucsf_pkg::*;
    logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic                   hold = 1'b0, pready, pslverr, slv;
    logic [ADDR_W-1:0]      paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rd;
    logic [NUM_CH-1:0]      rx_start = '0, rx_char_done = '0, rx_break = '0, rx_line_mark = '0;
    logic [NUM_CH-1:0]      rx_stop_bit = '0, rx_parity_bit = '0, tx_take, tx_last_stop, tx_char_valid;
    logic [NUM_CH-1:0][7:0] rx_data = '0, tx_char;
    int                     errors = 0, n_checks = 0;
    assign tx_take[1] = 1'b0;
    assign tx_last_stop[1] = 1'b0;
    always #50 pclk = ~pclk;
    ucsf_status #(.TX_DEPTH(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_start(rx_start), .rx_char_done(rx_char_done), .rx_data(rx_data), .rx_break(rx_break),
        .rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit), .rx_line_mark(rx_line_mark),
        .tx_take(tx_take), .tx_last_stop(tx_last_stop), .tx_char_valid(tx_char_valid), .tx_char(tx_char));
    ucsf_line_model line_u (.pclk(pclk), .presetn(presetn), .hold(hold), .valid(tx_char_valid[0]),
        .char_in(tx_char[0]), .take(tx_take[0]), .last_stop(tx_last_stop[0]));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rc(input logic [3:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h0);
        chk(rd, {24'h0, e});
    endtask
    task automatic rx_char(input logic [7:0] d, input logic brk, input logic stp, input logic par);
        rx_start[1] <= 1'b1;
        @(posedge pclk);
        rx_start[1] <= 1'b0;
        rx_char_done[1] <= 1'b1;
        rx_data[1] <= d;
        rx_break[1] <= brk;
        rx_stop_bit[1] <= stp;
        rx_parity_bit[1] <= par;
        @(posedge pclk);
        rx_char_done[1] <= 1'b0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////
    task automatic t_idle();
        rc(4'h1, 8'h00);
        rc(4'h9, 8'h00);
        apb(1'b1, 4'h1, 8'hff);
        rc(4'h1, 8'h00);
        apb(1'b0, 4'h4, 8'h0);
        chk({31'h0, slv}, 32'h1);
        $display("t_idle done");
    endtask
    task automatic t_tx();
        int n;
        n = 0;
        apb(1'b1, 4'h2, 8'h04);
        rc(4'h1, 8'h0c);
        hold <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 4'h1, 8'h0);
            if (i == 1) chk({31'h0, rd[ST_TXEMT]}, 32'h0);
            if (!rd[ST_TXRDY]) break;
            apb(1'b1, 4'h3, 8'h30 + 8'(i));
            n++;
        end
        chk({31'h0, rd[ST_TXRDY]}, 32'h0);
        apb(1'b1, 4'h3, 8'hee);
        hold <= 1'b0;
        for (int k = 0; k < 60 && rd !== 32'h0c; k++) apb(1'b0, 4'h1, 8'h0);
        chk(rd, 32'h0c);
        chk(32'(line_u.sent.size()), 32'(n));
        foreach (line_u.sent[k]) chk({24'h0, line_u.sent[k]}, 32'h30 + 32'(k));
        apb(1'b1, 4'h2, 8'h08);
        rc(4'h1, 8'h00);
        apb(1'b1, 4'h2, 8'h04);
        apb(1'b1, 4'h3, 8'h55);
        apb(1'b1, 4'h2, 8'h30);
        rc(4'h1, 8'h00);
        $display("t_tx done");
    endtask
    task automatic t_rx();
        logic [7:0] st[4] = '{8'h01, 8'h41, 8'h21, 8'h81};
        logic [7:0] dt[4] = '{8'h11, 8'h22, 8'h33, 8'h00};
        logic [7:0] pe[4] = '{8'h21, 8'h01, 8'h21, 8'h01};
        apb(1'b1, 4'h8, 8'h01);
        apb(1'b1, 4'ha, 8'h01);
        rx_char(8'h11, 1'b0, 1'b1, 1'b0);
        rx_char(8'h22, 1'b0, 1'b0, 1'b0);
        rx_char(8'h33, 1'b0, 1'b1, 1'b1);
        rx_char(8'h00, 1'b1, 1'b1, 1'b0);
        rx_char(8'h44, 1'b0, 1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            rc(4'h9, st[k]);
            rc(4'hb, dt[k]);
        end
        rc(4'h9, 8'h00);
        rx_line_mark[1] <= 1'b1;
        @(posedge pclk);
        rx_line_mark[1] <= 1'b0;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 4'h8, 8'(k + 1));
            rx_char(8'h00, 1'b0, 1'b1, 1'b1);
            rc(4'h9, pe[k]);
            apb(1'b0, 4'hb, 8'h0);
        end
        $display("t_rx done");
    endtask
    task automatic t_ovr();
        apb(1'b1, 4'h8, 8'h02);
        for (int i = 0; i < 9; i++) rx_char(8'h60 + 8'(i), 1'b0, 1'b1, 1'b0);
        rc(4'h9, 8'h03);
        rx_start[1] <= 1'b1;
        @(posedge pclk);
        rx_start[1] <= 1'b0;
        @(posedge pclk);
        rc(4'h9, 8'h13);
        rc(4'hb, 8'h60);
        rc(4'h9, 8'h11);
        apb(1'b1, 4'ha, 8'h40);
        rc(4'h9, 8'h01);
        rx_char(8'h70, 1'b0, 1'b1, 1'b0);
        rx_char(8'h71, 1'b0, 1'b1, 1'b0);
        rc(4'hb, 8'h61);
        rc(4'h9, 8'h03);
        for (int k = 0; k < 8; k++) rc(4'hb, k < 6 ? 8'h62 + 8'(k) : 8'h6a + 8'(k));
        rc(4'h9, 8'h00);
        $display("t_ovr done");
    endtask
    task automatic t_blk();
        apb(1'b1, 4'h8, 8'h0a);
        rx_char(8'h12, 1'b0, 1'b0, 1'b0);
        rx_char(8'h13, 1'b0, 1'b1, 1'b0);
        apb(1'b0, 4'hb, 8'h0);
        apb(1'b0, 4'hb, 8'h0);
        rc(4'h9, 8'h40);
        apb(1'b1, 4'ha, 8'h40);
        rc(4'h9, 8'h00);
        rx_char(8'h14, 1'b0, 1'b0, 1'b0);
        apb(1'b1, 4'ha, 8'h20);
        rc(4'h9, 8'h00);
        $display("t_blk done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #5000000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_idle();
        t_tx();
        t_rx();
        t_ovr();
        t_blk();
        give_verdict();
    end
endmodule
